/* File: rtl/brc_defs.vh */
// constants of the buffer ram control register bank
// Summary of operation
// RQ1 - reset command: write-only, code a9, value f6
// RQ2 - reset value clears registers, buffer memory kept
// RQ3 - any other value written is ignored
// RQ4 - one iso length sizes both iso buffers
// RQ5 - software keeps ack plus twice iso within 1000h
// RQ6 - iso length: read 2a, write aa, reset zero
// RQ7 - ack length: read 2b, write ab, reset zero
// RQ8 - status bits 0..2: iso0, iso1, ack full
// RQ9 - status bits 3..5: buffers consumed by controller
// RQ10 - status bits 15..6 read zero
// RQ11 - read-only iso0 read-back byte count, code 2d
// RQ12 - software loads counter from read-back count first
// RQ13 - pointer steps two; end sets irq bit 2
`ifndef BRC_DEFS_VH
`define BRC_DEFS_VH

`define BRC_ADDR_W          12
`define BRC_IDX_W           10

// register indices; byte address is four times the index
`define BRC_IDX_ISO_LEN_RD  10'h02a
`define BRC_IDX_ACK_LEN_RD  10'h02b
`define BRC_IDX_STATUS_RD   10'h02c
`define BRC_IDX_RDBACK_RD   10'h02d
`define BRC_IDX_SOFT_RST_WR 10'h0a9
`define BRC_IDX_ISO_LEN_WR  10'h0aa
`define BRC_IDX_ACK_LEN_WR  10'h0ab
`define BRC_IDX_IRQ_STAT    10'h030
`define BRC_IDX_IRQ_MASK    10'h031

`define BRC_SOFT_RST_VALUE  16'h00f6
`define BRC_REG_RESET       16'h0000
`define BRC_PTR_STEP        16'h0002
`define BRC_PTR_RESET       16'h0000

// buffer fill status fields
`define BRC_ST_ISO0_FULL    0
`define BRC_ST_ISO1_FULL    1
`define BRC_ST_ACK_FULL     2
`define BRC_ST_ISO0_DONE    3
`define BRC_ST_ISO1_DONE    4
`define BRC_ST_ACK_DONE     5
`define BRC_ST_USED_W       6

// buffer selects
`define BRC_SEL_ISO0        2'h0
`define BRC_SEL_ISO1        2'h1
`define BRC_SEL_ACK         2'h2

// interrupt status and mask fields
`define BRC_IRQ_W           3
`define BRC_IRQ_CONSUMED    0
`define BRC_IRQ_RDBACK      1
`define BRC_IRQ_EOT         2
`define BRC_IRQ_RESET       3'h0

`define BRC_RESP_OKAY       2'h0
`define BRC_RESP_SLVERR     2'h2

`endif

/* File: rtl/brc_eot_tracker.v */
// buffer ram word pointer and end-of-transfer detector
`timescale 1ns/1ps
`default_nettype none
`include "brc_defs.vh"

module brc_eot_tracker (
  input  wire        aclk,
  input  wire        clear,
  input  wire        start,
  input  wire [1:0]  start_sel,
  input  wire        start_write,
  input  wire        word_done,
  input  wire [15:0] xfer_count,
  output reg         active_reg,
  output reg  [1:0]  sel_reg,
  output reg         write_reg,
  output reg  [15:0] ptr_reg,
  output reg         eot_reg
);

  wire [15:0] ptr_next;

  assign ptr_next = ptr_reg + `BRC_PTR_STEP; // [RQ13]

  always @(posedge aclk) begin
    if (clear) begin
      active_reg <= 1'b0;
      sel_reg    <= `BRC_SEL_ISO0;
      write_reg  <= 1'b0;
      ptr_reg    <= `BRC_PTR_RESET;
      eot_reg    <= 1'b0;
    end else begin
      eot_reg <= 1'b0;
      if (start) begin
        active_reg <= 1'b1;
        sel_reg    <= start_sel;
        write_reg  <= start_write;
        ptr_reg    <= `BRC_PTR_RESET;
      end else if (active_reg && word_done) begin
        ptr_reg <= ptr_next; // [RQ13]
        // an odd count still ends on the word that covers its last byte
        if (ptr_next >= xfer_count) begin
          active_reg <= 1'b0;
          eot_reg    <= 1'b1; // [RQ13]
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: rtl/brc_regs.v */
// buffer ram control register bank with axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "brc_defs.vh"

module brc_regs (
  input  wire                  aclk,
  input  wire                  aresetn,
  // axi4-lite write address
  input  wire [`BRC_ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]            s_axi_awprot,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  // axi4-lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // axi4-lite read address
  input  wire [`BRC_ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]            s_axi_arprot,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  // axi4-lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // buffer ram access from the data ports
  input  wire                  buf_access_start,
  input  wire [1:0]            buf_access_sel,
  input  wire                  buf_access_write,
  input  wire                  buf_word_done,
  input  wire [15:0]           transfer_byte_counter,
  // controller side events
  input  wire                  iso0_consumed_evt,
  input  wire                  iso1_consumed_evt,
  input  wire                  ack_consumed_evt,
  input  wire                  iso0_count_valid,
  input  wire [15:0]           iso0_count,
  // outputs to the rest of the controller
  output wire [15:0]           iso_buffer_length,
  output wire [15:0]           ack_list_buffer_length,
  output wire [15:0]           buf_word_ptr,
  output wire                  soft_reset_pulse,
  output wire                  end_of_transfer_irq,
  output wire                  irq
);

  ////////////////////////////////////////////////////////////////////////
  // register state

  reg  [15:0]              iso_len_reg;
  reg  [15:0]              ack_len_reg;
  reg  [`BRC_ST_USED_W-1:0] status_reg;
  reg  [15:0]              rdback_reg;
  reg  [`BRC_IRQ_W-1:0]    irq_stat_reg;
  reg  [`BRC_IRQ_W-1:0]    irq_mask_reg;
  reg                      soft_rst_reg;

  reg  [`BRC_ST_USED_W-1:0] status_next;
  reg  [`BRC_IRQ_W-1:0]    irq_stat_next;
  reg  [`BRC_IRQ_W-1:0]    irq_set;

  // the bus side keeps its own state so an answer is never lost
  reg                      aw_held_reg;
  reg  [`BRC_ADDR_W-1:0]   aw_addr_reg;
  reg                      w_held_reg;
  reg  [31:0]              w_data_reg;
  reg  [3:0]               w_strb_reg;

  wire                     regs_clear;
  wire                     wr_commit;
  wire [`BRC_IDX_W-1:0]    wr_idx;
  wire [`BRC_IDX_W-1:0]    rd_idx;
  wire                     rd_take;
  wire                     eot_pulse;
  wire [1:0]               trk_sel;
  wire                     trk_write;

  reg                      wr_mapped;
  reg  [31:0]              rd_data;
  reg                      rd_mapped;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function [15:0] merge16;
    input [15:0] old_val;
    input [31:0] wdata;
    input [3:0]  strb;
    begin
      merge16[15:8] = strb[1] ? wdata[15:8] : old_val[15:8];
      merge16[7:0]  = strb[0] ? wdata[7:0]  : old_val[7:0];
    end
  endfunction

  // a soft reset clears the registers but not the bus handshake
  assign regs_clear = !aresetn || soft_rst_reg; // [RQ2]

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write path

  assign s_axi_awready = !aw_held_reg;
  assign s_axi_wready  = !w_held_reg;
  assign wr_commit     = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx        = aw_addr_reg[`BRC_ADDR_W-1:2];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      aw_addr_reg  <= {`BRC_ADDR_W{1'b0}};
      w_held_reg   <= 1'b0;
      w_data_reg   <= 32'h0;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BRC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_commit) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_commit) begin
        w_held_reg <= 1'b0;
      end
      if (wr_commit) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? `BRC_RESP_OKAY : `BRC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @* begin
    if (wr_idx == `BRC_IDX_SOFT_RST_WR) begin
      wr_mapped = 1'b1;
    end else if (wr_idx == `BRC_IDX_ISO_LEN_WR) begin
      wr_mapped = 1'b1;
    end else if (wr_idx == `BRC_IDX_ACK_LEN_WR) begin
      wr_mapped = 1'b1;
    end else if (wr_idx == `BRC_IDX_IRQ_STAT) begin
      wr_mapped = 1'b1;
    end else if (wr_idx == `BRC_IDX_IRQ_MASK) begin
      wr_mapped = 1'b1;
    end else begin
      wr_mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software reset command

  // only the full 16-bit reset value counts; anything else is dropped
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_reg <= 1'b0;
    end else begin
      soft_rst_reg <= wr_commit && (wr_idx == `BRC_IDX_SOFT_RST_WR) &&
                      (w_data_reg[15:0] == `BRC_SOFT_RST_VALUE); // [RQ1] [RQ3]
    end
  end

  assign soft_reset_pulse = soft_rst_reg; // [RQ2]

  ////////////////////////////////////////////////////////////////////////
  // buffer length registers

  // no check of the sum against the ram size: software keeps it in range
  always @(posedge aclk) begin
    if (regs_clear) begin
      iso_len_reg <= `BRC_REG_RESET; // [RQ6]
      ack_len_reg <= `BRC_REG_RESET; // [RQ7]
    end else if (wr_commit) begin
      if (wr_idx == `BRC_IDX_ISO_LEN_WR) begin
        iso_len_reg <= merge16(iso_len_reg, w_data_reg, w_strb_reg); // [RQ6]
      end else if (wr_idx == `BRC_IDX_ACK_LEN_WR) begin
        ack_len_reg <= merge16(ack_len_reg, w_data_reg, w_strb_reg); // [RQ7]
      end
    end
  end

  // both iso buffers take the one length
  assign iso_buffer_length      = iso_len_reg; // [RQ4]
  assign ack_list_buffer_length = ack_len_reg;

  ////////////////////////////////////////////////////////////////////////
  // buffer pointer and end of transfer

  brc_eot_tracker u_tracker (
    .aclk        (aclk),
    .clear       (regs_clear),
    .start       (buf_access_start),
    .start_sel   (buf_access_sel),
    .start_write (buf_access_write),
    .word_done   (buf_word_done),
    .xfer_count  (transfer_byte_counter),
    .active_reg  (),
    .sel_reg     (trk_sel),
    .write_reg   (trk_write),
    .ptr_reg     (buf_word_ptr),
    .eot_reg     (eot_pulse)
  );

  assign end_of_transfer_irq = eot_pulse;

  ////////////////////////////////////////////////////////////////////////
  // buffer fill status

  // a write that ends fills the buffer and clears its consumed flag;
  // a read that ends empties it; controller events set consumed flags
  always @* begin
    status_next = status_reg;
    if (eot_pulse) begin
      if (trk_sel == `BRC_SEL_ISO0) begin
        status_next[`BRC_ST_ISO0_FULL] = trk_write; // [RQ8] [RQ13]
        if (trk_write) begin
          status_next[`BRC_ST_ISO0_DONE] = 1'b0;
        end
      end else if (trk_sel == `BRC_SEL_ISO1) begin
        status_next[`BRC_ST_ISO1_FULL] = trk_write; // [RQ8] [RQ13]
        if (trk_write) begin
          status_next[`BRC_ST_ISO1_DONE] = 1'b0;
        end
      end else if (trk_sel == `BRC_SEL_ACK) begin
        status_next[`BRC_ST_ACK_FULL] = trk_write; // [RQ8] [RQ13]
        if (trk_write) begin
          status_next[`BRC_ST_ACK_DONE] = 1'b0;
        end
      end
    end
    // a consumed event wins over a clear in the same cycle
    if (iso0_consumed_evt) begin
      status_next[`BRC_ST_ISO0_DONE] = 1'b1; // [RQ9]
    end
    if (iso1_consumed_evt) begin
      status_next[`BRC_ST_ISO1_DONE] = 1'b1; // [RQ9]
    end
    if (ack_consumed_evt) begin
      status_next[`BRC_ST_ACK_DONE] = 1'b1; // [RQ9]
    end
  end

  always @(posedge aclk) begin
    if (regs_clear) begin
      status_reg <= {`BRC_ST_USED_W{1'b0}};
    end else begin
      status_reg <= status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // iso0 read-back count

  always @(posedge aclk) begin
    if (regs_clear) begin
      rdback_reg <= `BRC_REG_RESET; // [RQ11]
    end else if (iso0_count_valid) begin
      rdback_reg <= iso0_count; // [RQ11]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  always @* begin
    irq_set = {`BRC_IRQ_W{1'b0}};
    irq_set[`BRC_IRQ_CONSUMED] = iso0_consumed_evt || iso1_consumed_evt ||
                                 ack_consumed_evt;
    irq_set[`BRC_IRQ_RDBACK]   = iso0_count_valid;
    irq_set[`BRC_IRQ_EOT]      = eot_pulse; // [RQ13]
    irq_stat_next = irq_stat_reg;
    if (wr_commit && (wr_idx == `BRC_IDX_IRQ_STAT) && w_strb_reg[0]) begin
      irq_stat_next = irq_stat_reg & ~w_data_reg[`BRC_IRQ_W-1:0];
    end
    // set wins over a write-one-to-clear in the same cycle
    irq_stat_next = irq_stat_next | irq_set;
  end

  always @(posedge aclk) begin
    if (regs_clear) begin
      irq_stat_reg <= `BRC_IRQ_RESET;
      irq_mask_reg <= `BRC_IRQ_RESET;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_commit && (wr_idx == `BRC_IDX_IRQ_MASK) && w_strb_reg[0]) begin
        irq_mask_reg <= w_data_reg[`BRC_IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read path

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[`BRC_ADDR_W-1:2];

  // the reset command and write codes read back as unmapped
  always @* begin
    rd_data   = 32'h0;
    rd_mapped = 1'b1;
    if (rd_idx == `BRC_IDX_ISO_LEN_RD) begin
      rd_data[15:0] = iso_len_reg; // [RQ6]
    end else if (rd_idx == `BRC_IDX_ACK_LEN_RD) begin
      rd_data[15:0] = ack_len_reg; // [RQ7]
    end else if (rd_idx == `BRC_IDX_STATUS_RD) begin
      // upper bits stay zero from the default
      rd_data[`BRC_ST_USED_W-1:0] = status_reg; // [RQ8] [RQ9] [RQ10]
    end else if (rd_idx == `BRC_IDX_RDBACK_RD) begin
      rd_data[15:0] = rdback_reg; // [RQ11]
    end else if (rd_idx == `BRC_IDX_IRQ_STAT) begin
      rd_data[`BRC_IRQ_W-1:0] = irq_stat_reg;
    end else if (rd_idx == `BRC_IDX_IRQ_MASK) begin
      rd_data[`BRC_IRQ_W-1:0] = irq_mask_reg;
    end else begin
      rd_mapped = 1'b0;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `BRC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_mapped ? `BRC_RESP_OKAY : `BRC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: tb/brc_regs_sva.sv */
// port checks for the buffer ram control register bank
`timescale 1ns/1ps
`default_nettype none
`include "brc_defs.vh"
module brc_regs_sva (
  input wire                   aclk,
  input wire                   aresetn,
  input wire [`BRC_ADDR_W-1:0] s_axi_araddr,
  input wire                   s_axi_arvalid,
  input wire                   s_axi_arready,
  input wire [31:0]            s_axi_rdata,
  input wire                   s_axi_rvalid,
  input wire                   buf_access_start,
  input wire                   buf_word_done,
  input wire [15:0]            iso_buffer_length,
  input wire [15:0]            ack_list_buffer_length,
  input wire [15:0]            buf_word_ptr,
  input wire                   soft_reset_pulse,
  input wire                   end_of_transfer_irq,
  input wire                   irq
);
  reg [`BRC_ADDR_W-1:0] ar_q;
  // read data comes after the address has left the bus, so keep it
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      ar_q <= s_axi_araddr;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rst_len_zero: assert property (soft_reset_pulse |=>
    iso_buffer_length == 16'h0000 && ack_list_buffer_length == 16'h0000)
    else $error("lengths not cleared");
  a_rst_ptr_once: assert property (soft_reset_pulse |=> !soft_reset_pulse
    && buf_word_ptr == 16'h0000 && !irq) else $error("soft reset clear wrong");
  a_eot_one_cycle: assert property (end_of_transfer_irq |=> !end_of_transfer_irq)
    else $error("end pulse too long");
  a_eot_after_word: assert property ($rose(end_of_transfer_irq) |-> $past(buf_word_done))
    else $error("end pulse without word");
  a_ptr_step_two: assert property ($changed(buf_word_ptr) |-> buf_word_ptr == 16'h0000
    || buf_word_ptr == $past(buf_word_ptr) + 16'h0002) else $error("pointer step wrong");
  a_ptr_idle_hold: assert property (!buf_word_done && !buf_access_start && !soft_reset_pulse
    |=> $stable(buf_word_ptr)) else $error("pointer moved idle");
  a_start_ptr_zero: assert property (buf_access_start |=> buf_word_ptr == 16'h0000)
    else $error("start did not zero pointer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  a_status_rsvd: assert property (s_axi_rvalid && ar_q == 12'h0b0
    |-> s_axi_rdata[31:6] == 26'h0) else $error("status reserved bits set");
  c_soft_reset: cover property (soft_reset_pulse);
  c_end_xfer: cover property (end_of_transfer_irq);
  c_irq_rise: cover property ($rose(irq));
endmodule
bind brc_regs brc_regs_sva brc_regs_sva_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .buf_access_start(buf_access_start),
  .buf_word_done(buf_word_done), .iso_buffer_length(iso_buffer_length),
  .ack_list_buffer_length(ack_list_buffer_length), .buf_word_ptr(buf_word_ptr),
  .soft_reset_pulse(soft_reset_pulse), .end_of_transfer_irq(end_of_transfer_irq), .irq(irq));
`default_nettype wire

/* File: tb/brc_host.sv */
// host processor model: axi4-lite master
`timescale 1ns/1ps
`default_nettype none
`include "brc_defs.vh"
module brc_host (
  input  wire                   aclk,
  output reg  [`BRC_ADDR_W-1:0] awaddr,
  output reg                    awvalid,
  input  wire                   awready,
  output reg  [31:0]            wdata,
  output reg                    wvalid,
  input  wire                   wready,
  input  wire [1:0]             bresp,
  input  wire                   bvalid,
  output reg                    bready,
  output reg  [`BRC_ADDR_W-1:0] araddr,
  output reg                    arvalid,
  input  wire                   arready,
  input  wire [31:0]            rdata,
  input  wire [1:0]             rresp,
  input  wire                   rvalid,
  output reg                    rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = 47'h0;
    {araddr, arvalid, rready} = 14'h0;
  end
  // address and data are each released at the edge that takes them
  task wr(input [`BRC_ADDR_W-1:0] a, input [31:0] v, output [1:0] resp);
    begin
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [`BRC_ADDR_W-1:0] a, output [31:0] v, output [1:0] resp);
    begin
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      v = rdata;
      resp = rresp;
      rready <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/brc_regs_bench.sv */
// self-checking bench for the buffer ram control register bank
`timescale 1ns/1ps
`default_nettype none
`include "brc_defs.vh"
module brc_regs_bench;
  reg                    aclk;
  reg                    aresetn;
  reg                    start, wr, done, cv, ev0, ev1, ev2;
  reg  [1:0]             sel;
  reg  [15:0]            cnt, c0;
  wire [`BRC_ADDR_W-1:0] aw_a, ar_a;
  wire [31:0]            w_d, r_d;
  wire [1:0]             b_resp, r_resp;
  wire                   aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  wire [15:0]            iso_len, ack_len, ptr;
  wire                   srp, eot, irq;
  integer                error_cnt, checks, i;
  integer                srp_cnt, eot_cnt;
  reg  [31:0]            d;
  reg  [1:0]             r;
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // end and soft reset pulses stand one cycle, so count them at the edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      srp_cnt <= 0;
      eot_cnt <= 0;
    end else begin
      if (srp) srp_cnt <= srp_cnt + 1;
      if (eot) eot_cnt <= eot_cnt + 1;
    end
  end
  brc_host brc_host_i (.aclk(aclk), .awaddr(aw_a), .awvalid(aw_v), .awready(aw_r), .wdata(w_d),
    .wvalid(w_v), .wready(w_r), .bresp(b_resp), .bvalid(b_v), .bready(b_r), .araddr(ar_a),
    .arvalid(ar_v), .arready(ar_r), .rdata(r_d), .rresp(r_resp), .rvalid(r_v), .rready(r_r));
  brc_regs brc_regs_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0), .s_axi_arvalid(ar_v),
    .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v),
    .s_axi_rready(r_r), .buf_access_start(start), .buf_access_sel(sel),
    .buf_access_write(wr), .buf_word_done(done), .transfer_byte_counter(cnt),
    .iso0_consumed_evt(ev0), .iso1_consumed_evt(ev1), .ack_consumed_evt(ev2),
    .iso0_count_valid(cv), .iso0_count(c0), .iso_buffer_length(iso_len),
    .ack_list_buffer_length(ack_len), .buf_word_ptr(ptr), .soft_reset_pulse(srp),
    .end_of_transfer_irq(eot), .irq(irq));
  //////////////////////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] want);
    begin
      checks = checks + 1;
      if (seen !== want) begin
        error_cnt = error_cnt + 1;
        $display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
      end
    end
  endtask
  task rdc(input [`BRC_ADDR_W-1:0] a, input [31:0] want, input [1:0] er);
    begin
      brc_host_i.rd(a, d, r);
      chk(d, want);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  task wrc(input [`BRC_ADDR_W-1:0] a, input [31:0] v, input [1:0] er);
    begin
      brc_host_i.wr(a, v, r);
      chk({30'h0, r}, {30'h0, er});
    end
  endtask
  // odd byte counts still move a whole last word
  task access(input [1:0] s, input w, input [15:0] n);
    integer k;
    begin
      @(posedge aclk);
      start <= 1'b1;
      sel   <= s;
      wr    <= w;
      cnt   <= n;
      @(posedge aclk);
      start <= 1'b0;
      done  <= 1'b1;
      for (k = 1; k < (n + 1) / 2; k = k + 1)
        @(posedge aclk);
      @(posedge aclk);
      done <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task evt(input [2:0] m);
    begin
      @(posedge aclk);
      {ev2, ev1, ev0} <= m;
      @(posedge aclk);
      {ev2, ev1, ev0} <= 3'h0;
      repeat (2) @(posedge aclk);
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d, errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    {start, wr, done, cv, ev0, ev1, ev2} = 7'h00;
    sel = 2'h0;
    cnt = 16'h0000;
    c0 = 16'h0000;
    error_cnt = 0;
    checks = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(12'h0a8, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0ac, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0b0, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0b4, 32'h0, `BRC_RESP_OKAY);
    // lengths chosen so ack plus twice iso fills the ram exactly
    wrc(12'h2a8, 32'h400, `BRC_RESP_OKAY);
    wrc(12'h2ac, 32'h800, `BRC_RESP_OKAY);
    rdc(12'h0a8, 32'h400, `BRC_RESP_OKAY);
    rdc(12'h0ac, 32'h800, `BRC_RESP_OKAY);
    chk({16'h0, iso_len}, 32'h400);
    chk({16'h0, ack_len}, 32'h800);
    wrc(12'h0a8, 32'h0, `BRC_RESP_SLVERR);
    rdc(12'h3fc, 32'h0, `BRC_RESP_SLVERR);
    wrc(12'h0c4, 32'h7, `BRC_RESP_OKAY);
    for (i = 0; i < 3; i = i + 1)
      access(i[1:0], 1'b1, 16'h0004);
    rdc(12'h0b0, 32'h07, `BRC_RESP_OKAY);
    evt(3'h7);
    rdc(12'h0b0, 32'h3f, `BRC_RESP_OKAY);
    access(`BRC_SEL_ISO0, 1'b0, 16'h0003);
    chk({16'h0, ptr}, 32'h4);
    rdc(12'h0b0, 32'h3e, `BRC_RESP_OKAY);
    @(posedge aclk);
    c0 <= 16'h0123;
    cv <= 1'b1;
    @(posedge aclk);
    cv <= 1'b0;
    rdc(12'h0b4, 32'h123, `BRC_RESP_OKAY);
    access(`BRC_SEL_ISO0, 1'b0, d[15:0]);
    rdc(12'h0c0, 32'h7, `BRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wrc(12'h0c0, 32'h7, `BRC_RESP_OKAY);
    rdc(12'h0c0, 32'h0, `BRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wrc(12'h0c4, 32'h0, `BRC_RESP_OKAY);
    evt(3'h1);
    chk({31'h0, irq}, 32'h0);
    wrc(12'h0c4, 32'h1, `BRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    wrc(12'h2a4, 32'h1f6, `BRC_RESP_OKAY);
    rdc(12'h0a8, 32'h400, `BRC_RESP_OKAY);
    rdc(12'h0b0, 32'h3e, `BRC_RESP_OKAY);
    chk(srp_cnt, 0);
    wrc(12'h2a4, {16'h0, `BRC_SOFT_RST_VALUE}, `BRC_RESP_OKAY);
    rdc(12'h0a8, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0ac, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0b0, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0b4, 32'h0, `BRC_RESP_OKAY);
    rdc(12'h0c4, 32'h0, `BRC_RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    chk(srp_cnt, 1);
    chk(eot_cnt, 5);
    wrap_up;
  end
  // a full pass takes well under a thousand bus cycles; this cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt = error_cnt + 1;
    wrap_up;
  end
endmodule
`default_nettype wire
